// ==== logic/load_store_exchange_exec.sv ====
// Purpose: Executes loads, stores, exchanges, multi-register transfers and unsigned compares
// Assumes: Effective address arrives with the instruction; memory answers on ref_clk
// Notes: Holds the sixteen general registers and the condition code
//
// How it works
// [RULE1] Halfword load zero-extends into bits 16:31; G set when nonzero, rest cleared
// [RULE2] Software keeps halfword operands halfword aligned
// [RULE3] Software keeps fullword operands of multi and word transfers aligned
// [RULE4] Multi fill loads consecutive registers from consecutive words, ending at 15
// [RULE5] Effective address is captured before any register is written
// [RULE6] Start address stays visible after a memory or translator fault
// [RULE7] Byte loads put the byte in bits 24:31 and clear bits 0:23
// [RULE8] Register byte load takes the byte from the second register field
// [RULE9] Halfword swap crosses source halves into destination; source kept
// [RULE10] Same register in both fields swaps its halves in place
// [RULE11] Byte swap exchanges low two bytes into destination low half
// [RULE12] Word store writes all 32 register bits to memory
// [RULE13] Halfword store writes register bits 16:31
// [RULE14] Multi store writes consecutive registers to consecutive words, ending at 15
// [RULE15] Byte store writes register bits 24:31 to the byte location
// [RULE16] Register byte store copies low byte into second register, upper kept
// [RULE17] Loads other than halfword, swaps and stores keep the condition code
// [RULE18] Unsigned compare decodes as 55, 05 and F5
// [RULE19] Unsigned compare sets only the condition code, operands untouched
// [RULE20] Registers are 32 bits, bit 0 most significant, numbered 0 to 15
// [RULE21] Multi fill decodes as D1
`timescale 1ns/1ns
`default_nettype none
`include "lsx_consts.svh"
module load_store_exchange_exec
(
    // Clock, reset, enable
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic clk_en,
    // Instruction issue
    input wire logic instr_valid,
    output logic instr_ready,
    input wire logic [7:0] opcode,
    input wire logic [3:0] first_reg_field,
    input wire logic [3:0] second_reg_field,
    input wire logic [31:0] eff_addr,
    input wire logic [31:0] imm_operand,
    // Completion
    output logic done,
    output logic fault,
    output logic unknown_op,
    output logic [31:0] retry_addr,
    output logic [3:0] cond_code,
    // Register file access from the rest of the processor
    input wire logic ext_wr_en,
    input wire logic [3:0] ext_wr_sel,
    input wire logic [31:0] ext_wr_data,
    input wire logic [3:0] rd_sel,
    output logic [31:0] rd_data,
    // Memory through the address translator
    output logic mem_req,
    output logic mem_we,
    output logic [1:0] mem_size,
    output logic [31:0] mem_addr,
    output logic [31:0] mem_wdata,
    input wire logic mem_ack,
    input wire logic mem_err,
    input wire logic [31:0] mem_rdata
);
    lsx_pkg::exec_state_t state_r;
    lsx_pkg::exec_state_t state_nxt;
    lsx_pkg::word_t regs_r [16];
    lsx_pkg::cc_t cc_r;
    lsx_pkg::cc_t cc_nxt;
    logic [7:0] op_r;
    lsx_pkg::word_t addr_r;
    logic done_r;
    logic fault_r;
    logic unknown_r;

    xfer_seq_if sq ();

    xfer_sequencer u_seq
    (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .clk_en(clk_en),
        .sq(sq)
    );

    // Decode of the issuing opcode
    wire is_load_half = (opcode == `OP_LOAD_HALF_ZERO_EXT);
    wire is_multi_fill = (opcode == `OP_MULTI_REG_FILL); // RULE21
    wire is_byte_fill = (opcode == `OP_BYTE_FILL_ZERO_EXT);
    wire is_byte_copy_reg = (opcode == `OP_BYTE_COPY_REG_ZERO_EXT);
    wire is_half_swap = (opcode == `OP_HALF_SWAP_REG);
    wire is_byte_swap = (opcode == `OP_BYTE_SWAP_REG);
    wire is_word_write = (opcode == `OP_WORD_WRITE_MEM);
    wire is_half_write = (opcode == `OP_HALF_WRITE_MEM);
    wire is_multi_write = (opcode == `OP_MULTI_REG_WRITE_MEM);
    wire is_byte_write = (opcode == `OP_BYTE_WRITE_MEM);
    wire is_byte_copy_low = (opcode == `OP_BYTE_COPY_INTO_REG_LOW);
    wire is_ucmp_word = (opcode == `OP_UNSIGNED_COMPARE_WORD); // RULE18
    wire is_ucmp_reg = (opcode == `OP_UNSIGNED_COMPARE_REG); // RULE18
    wire is_ucmp_imm = (opcode == `OP_UNSIGNED_COMPARE_IMM); // RULE18

    wire uses_mem = is_load_half | is_multi_fill | is_byte_fill | is_word_write
                  | is_half_write | is_multi_write | is_byte_write | is_ucmp_word;
    wire reg_only = is_byte_copy_reg | is_half_swap | is_byte_swap | is_byte_copy_low
                  | is_ucmp_reg | is_ucmp_imm;
    wire known_op = uses_mem | reg_only;

    wire in_idle = (state_r == lsx_pkg::ST_IDLE);
    wire in_access = (state_r == lsx_pkg::ST_ACCESS);
    wire issue = clk_en & instr_valid & in_idle;
    wire issue_mem = issue & uses_mem;
    wire issue_reg = issue & reg_only;

    // Decode of the instruction held during a memory access
    wire run_load_half = (op_r == `OP_LOAD_HALF_ZERO_EXT);
    wire run_multi_fill = (op_r == `OP_MULTI_REG_FILL);
    wire run_byte_fill = (op_r == `OP_BYTE_FILL_ZERO_EXT);
    wire run_half_write = (op_r == `OP_HALF_WRITE_MEM);
    wire run_multi_write = (op_r == `OP_MULTI_REG_WRITE_MEM);
    wire run_byte_write = (op_r == `OP_BYTE_WRITE_MEM);
    wire run_ucmp_word = (op_r == `OP_UNSIGNED_COMPARE_WORD);
    wire run_multi = run_multi_fill | run_multi_write;
    wire run_store = (op_r == `OP_WORD_WRITE_MEM) | run_half_write | run_multi_write | run_byte_write;
    wire run_load = run_load_half | run_multi_fill | run_byte_fill;

    wire beat_ok = clk_en & in_access & mem_ack & ~mem_err;
    wire beat_err = clk_en & in_access & mem_ack & mem_err;
    wire more_beats = run_multi & ~sq.last; // RULE4 RULE14
    wire finish = beat_ok & ~more_beats;

    // Operand reads; bits 16:31 are [15:0], bits 24:31 are [7:0]
    wire [31:0] src1 = regs_r[first_reg_field]; // RULE20
    wire [31:0] src2 = regs_r[second_reg_field];
    wire [31:0] cur_src = regs_r[sq.cur_reg];

    // {C,V,G,L} for an unsigned compare; V is left clear
    function automatic lsx_pkg::cc_t ucmp(input lsx_pkg::word_t a, input lsx_pkg::word_t b);
        if (a < b)
            ucmp = `CC_LESS;
        else if (a > b)
            ucmp = `CC_GREATER;
        else
            ucmp = `CC_EQUAL;
    endfunction

    // Register-only results, all landing in the first register except the low-byte copy into the second register
    wire [31:0] byte_copy_val = {`FILL_24, src2[7:0]}; // RULE7 RULE8
    wire [31:0] half_swap_val = {src2[15:0], src2[31:16]}; // RULE9 RULE10
    wire [31:0] byte_swap_val = {src1[31:16], src2[7:0], src2[15:8]}; // RULE11
    wire [31:0] copy_low_val = {src2[31:8], src1[7:0]}; // RULE16
    wire [31:0] reg_op_val = is_byte_copy_reg ? byte_copy_val
                           : is_half_swap ? half_swap_val
                           : is_byte_swap ? byte_swap_val
                           : copy_low_val;
    wire reg_op_writes = is_byte_copy_reg | is_half_swap | is_byte_swap | is_byte_copy_low;
    wire [3:0] reg_op_dest = is_byte_copy_low ? second_reg_field : first_reg_field; // RULE16

    // Memory load results
    wire [31:0] half_load_val = {`FILL_HALF, mem_rdata[15:0]}; // RULE1
    wire [31:0] byte_load_val = {`FILL_24, mem_rdata[7:0]}; // RULE7
    wire [31:0] mem_load_val = run_load_half ? half_load_val
                             : run_byte_fill ? byte_load_val
                             : mem_rdata; // RULE4

    // Single write port of the register file
    wire wr_reg_op = issue_reg & reg_op_writes;
    wire wr_mem_load = beat_ok & run_load;
    wire wr_ext = clk_en & in_idle & ext_wr_en & ~wr_reg_op;
    wire wr_en = wr_reg_op | wr_mem_load | wr_ext;
    wire [3:0] wr_sel = wr_mem_load ? sq.cur_reg : wr_reg_op ? reg_op_dest : ext_wr_sel;
    wire [31:0] wr_data = wr_mem_load ? mem_load_val : wr_reg_op ? reg_op_val : ext_wr_data;

    // Condition code: only the halfword load and the compares touch it
    always_comb
    begin
        cc_nxt = cc_r; // RULE17
        if (issue_reg && is_ucmp_reg)
            cc_nxt = ucmp(src1, src2); // RULE19
        else if (issue_reg && is_ucmp_imm)
            cc_nxt = ucmp(src1, imm_operand); // RULE19
        else if (beat_ok && run_ucmp_word)
            cc_nxt = ucmp(cur_src, mem_rdata); // RULE19
        else if (beat_ok && run_load_half)
            cc_nxt = (mem_rdata[15:0] != `FILL_HALF) ? `CC_GREATER : `CC_ZERO; // RULE1
    end

    // Control sequence
    always_comb
    begin
        state_nxt = state_r;
        case (state_r)
            lsx_pkg::ST_IDLE:
            begin
                if (issue_mem)
                    state_nxt = lsx_pkg::ST_ACCESS;
            end
            lsx_pkg::ST_ACCESS:
            begin
                if (beat_err)
                    state_nxt = lsx_pkg::ST_ABORT;
                else if (finish)
                    state_nxt = lsx_pkg::ST_IDLE;
            end
            lsx_pkg::ST_ABORT:
            begin
                state_nxt = lsx_pkg::ST_IDLE;
            end
            default:
            begin
                state_nxt = lsx_pkg::ST_IDLE;
            end
        endcase
    end

    // Sequencer: loaded with the address latched at issue, so later register
    // writes cannot disturb the walk even when they hit index registers
    assign sq.start = issue_mem; // RULE5
    assign sq.first_reg = first_reg_field;
    assign sq.base_addr = eff_addr; // RULE5
    assign sq.step = beat_ok & more_beats; // RULE4 RULE14

    // Memory side; address and data come straight from held flops
    assign mem_req = in_access;
    assign mem_we = run_store;
    assign mem_size = (run_load_half | run_half_write) ? `SIZE_HALF
                    : (run_byte_fill | run_byte_write) ? `SIZE_BYTE
                    : `SIZE_WORD; // RULE2 RULE3
    assign mem_addr = sq.cur_addr;
    assign mem_wdata = run_half_write ? {`FILL_HALF, cur_src[15:0]} // RULE13
                     : run_byte_write ? {`FILL_24, cur_src[7:0]} // RULE15
                     : cur_src; // RULE12 RULE14

    assign instr_ready = in_idle;
    assign done = done_r;
    assign fault = fault_r;
    assign unknown_op = unknown_r;
    assign retry_addr = addr_r; // RULE6
    assign cond_code = cc_r;
    assign rd_data = regs_r[rd_sel];

    // General registers, one flop word per entry
    genvar gi;
    generate
        for (gi = 0; gi < 16; gi++)
        begin : g_reg
            always_ff @(posedge ref_clk)
            begin
                if (!rst_n)
                    regs_r[gi] <= `REG_RESET;
                else if (wr_en && wr_sel == 4'(gi))
                    regs_r[gi] <= wr_data;
            end
        end
    endgenerate

    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            state_r <= lsx_pkg::ST_IDLE;
            cc_r <= `CC_RESET;
        end
        else if (clk_en)
        begin
            state_r <= state_nxt;
            cc_r <= cc_nxt;
        end
    end

    // The start address is held until the next instruction issues so a
    // faulted transfer can be restarted from it
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            op_r <= `OP_WORD_WRITE_MEM;
            addr_r <= `ZERO_WORD;
        end
        else if (issue)
        begin
            op_r <= opcode;
            addr_r <= eff_addr; // RULE5 RULE6
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            done_r <= 1'b0;
            fault_r <= 1'b0;
            unknown_r <= 1'b0;
        end
        else if (clk_en)
        begin
            done_r <= issue_reg | (issue & ~known_op) | finish | beat_err;
            unknown_r <= issue & ~known_op;
            if (issue)
                fault_r <= 1'b0;
            else if (beat_err)
                fault_r <= 1'b1; // RULE6
        end
    end
endmodule
`default_nettype wire

// ==== logic/xfer_sequencer.sv ====
// Purpose: Walks register number and fullword address through a transfer
// Assumes: Start and step never coincide
// Notes: Single transfers use the same counters with one beat
`timescale 1ns/1ns
`default_nettype none
`include "lsx_consts.svh"
module xfer_sequencer
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic clk_en,
    // Control side
    xfer_seq_if.seq sq
);
    lsx_pkg::reg_idx_t cur_reg_r;
    lsx_pkg::word_t cur_addr_r;

    assign sq.cur_reg = cur_reg_r;
    assign sq.cur_addr = cur_addr_r;
    assign sq.last = (cur_reg_r == `LAST_REG);

    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            cur_reg_r <= `LAST_REG;
            cur_addr_r <= `ZERO_WORD;
        end
        else if (clk_en && sq.start)
        begin
            cur_reg_r <= sq.first_reg;
            cur_addr_r <= sq.base_addr;
        end
        else if (clk_en && sq.step)
        begin
            cur_reg_r <= cur_reg_r + `REG_STEP;
            cur_addr_r <= cur_addr_r + `WORD_STEP;
        end
    end
endmodule
`default_nettype wire

// ==== shared/lsx_consts.svh ====
// Purpose: Named opcodes, field values and fixed figures of the load/store/exchange unit
// Assumes: Bit 0 of a register is its most significant bit; bits 16:31 map to [15:0]
// Notes: Definitions only
`ifndef LSX_CONSTS_SVH
`define LSX_CONSTS_SVH

// Opcodes
`define OP_LOAD_HALF_ZERO_EXT 8'h73
`define OP_MULTI_REG_FILL 8'hd1
`define OP_BYTE_FILL_ZERO_EXT 8'hd3
`define OP_BYTE_COPY_REG_ZERO_EXT 8'h93
`define OP_HALF_SWAP_REG 8'h34
`define OP_BYTE_SWAP_REG 8'h94
`define OP_WORD_WRITE_MEM 8'h50
`define OP_HALF_WRITE_MEM 8'h40
`define OP_MULTI_REG_WRITE_MEM 8'hd0
`define OP_BYTE_WRITE_MEM 8'hd2
`define OP_BYTE_COPY_INTO_REG_LOW 8'h92
`define OP_UNSIGNED_COMPARE_WORD 8'h55
`define OP_UNSIGNED_COMPARE_REG 8'h05
`define OP_UNSIGNED_COMPARE_IMM 8'hf5

// Register numbering and multi-register stepping
`define LAST_REG 4'hf
`define REG_STEP 4'h1
`define WORD_STEP 32'h00000004
`define REG_RESET 32'h00000000

// Memory access sizes
`define SIZE_BYTE 2'h0
`define SIZE_HALF 2'h1
`define SIZE_WORD 2'h2

// Condition code {C,V,G,L}
`define CC_RESET 4'h0
`define CC_ZERO 4'h0
`define CC_GREATER 4'h2
`define CC_LESS 4'h9
`define CC_EQUAL 4'h0

// Fill patterns
`define FILL_HALF 16'h0000
`define FILL_24 24'h000000
`define ZERO_WORD 32'h00000000

`endif

// ==== shared/lsx_pkg.sv ====
// Purpose: Types shared by the load/store/exchange unit
// Assumes: Constants live in lsx_consts.svh
// Notes: Nothing here is imported; users write lsx_pkg::name
package lsx_pkg;
    typedef logic [31:0] word_t;
    typedef logic [3:0] reg_idx_t;
    typedef logic [3:0] cc_t;
    typedef enum logic [2:0]
    {
        ST_IDLE = 3'b001,
        ST_ACCESS = 3'b010,
        ST_ABORT = 3'b100
    } exec_state_t;
endpackage

// ==== shared/xfer_seq_if.sv ====
// Purpose: Link between the execution control and the transfer sequencer
// Assumes: Both ends run on ref_clk
// Notes: The sequencer owns the current register number and current address
`timescale 1ns/1ns
`default_nettype none
interface xfer_seq_if;
    logic start;
    logic step;
    lsx_pkg::reg_idx_t first_reg;
    lsx_pkg::word_t base_addr;
    lsx_pkg::reg_idx_t cur_reg;
    lsx_pkg::word_t cur_addr;
    logic last;
    modport ctrl (output start, output step, output first_reg, output base_addr,
                  input cur_reg, input cur_addr, input last);
    modport seq (input start, input step, input first_reg, input base_addr,
                 output cur_reg, output cur_addr, output last);
endinterface
`default_nettype wire

// ==== tb/lsx_assertions.sv ====
// Purpose: Port-level checks of the load/store/exchange unit
// Assumes: One clock domain, reset synchronous active low
// Notes: Bound to the top module after the module body
`timescale 1ns/1ns
`default_nettype none
`include "lsx_consts.svh"
module lsx_assertions
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic clk_en,
    // Issue and completion
    input wire logic instr_valid,
    input wire logic instr_ready,
    input wire logic [7:0] opcode,
    input wire logic [31:0] eff_addr,
    input wire logic done,
    input wire logic fault,
    input wire logic unknown_op,
    input wire logic [31:0] retry_addr,
    input wire logic [3:0] cond_code,
    // Memory link
    input wire logic mem_req,
    input wire logic mem_we,
    input wire logic [1:0] mem_size,
    input wire logic [31:0] mem_addr,
    input wire logic mem_ack,
    input wire logic mem_err
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    wire issue = instr_valid && instr_ready && clk_en;
    wire mem_op = opcode inside {8'h73, 8'hd1, 8'hd3, 8'h50, 8'h40, 8'hd0, 8'hd2, 8'h55};
    wire keep_cc = opcode inside {8'hd1, 8'hd3, 8'h93, 8'h34, 8'h94, 8'h50, 8'h40, 8'hd0, 8'hd2, 8'h92};
    wire known = mem_op || opcode inside {8'h93, 8'h34, 8'h94, 8'h92, 8'h05, 8'hf5};
    wire good_beat = mem_req && mem_ack && !mem_err && clk_en;
    wire bad_beat = mem_req && mem_ack && mem_err && clk_en;
    logic cc_lock_r;
    // Lock spans issue to done so slow memory ops are covered too
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
            cc_lock_r <= 1'h0;
        else if (issue)
            cc_lock_r <= keep_cc;
        else if (clk_en && done)
            cc_lock_r <= 1'h0;
    end
    a_first_addr: assert property (issue && mem_op |=> mem_req && mem_addr == $past(eff_addr))
        else $error("first beat address differs from effective address");
    a_beat_step: assert property (good_beat ##1 mem_req |-> mem_addr == $past(mem_addr) + `WORD_STEP)
        else $error("next beat address not previous plus four");
    a_retry_addr: assert property (issue |=> retry_addr == $past(eff_addr))
        else $error("retry address not captured at issue");
    // Done and fault rise together on the edge after the failed beat; the idle return follows
    a_err_abort: assert property (bad_beat |=> !mem_req && !instr_ready && done && fault ##1 !done && fault)
        else $error("failed beat did not end with fault");
    a_half_load: assert property (issue && opcode == 8'h73 |=> mem_req && !mem_we && mem_size == `SIZE_HALF)
        else $error("halfword load access wrong");
    a_multi_load: assert property (issue && opcode == 8'hd1 |=> mem_req && !mem_we && mem_size == `SIZE_WORD)
        else $error("multi fill access wrong");
    a_word_store: assert property (issue && opcode == 8'h50 |=> mem_we && mem_size == `SIZE_WORD)
        else $error("word store access wrong");
    a_half_store: assert property (issue && opcode == 8'h40 |=> mem_we && mem_size == `SIZE_HALF)
        else $error("halfword store access wrong");
    a_byte_store: assert property (issue && opcode == 8'hd2 |=> mem_we && mem_size == `SIZE_BYTE)
        else $error("byte store access wrong");
    a_cc_keep: assert property (cc_lock_r |-> $stable(cond_code))
        else $error("condition code moved");
    a_cmp_reg: assert property (issue && opcode inside {8'h05, 8'hf5} |=> done && !unknown_op && !mem_req)
        else $error("register compare not completed");
    a_unknown_op: assert property (issue && !known |=> done && unknown_op)
        else $error("unknown opcode not flagged");
endmodule
bind load_store_exchange_exec lsx_assertions chk_i
(
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .clk_en(clk_en),
    .instr_valid(instr_valid),
    .instr_ready(instr_ready),
    .opcode(opcode),
    .eff_addr(eff_addr),
    .done(done),
    .fault(fault),
    .unknown_op(unknown_op),
    .retry_addr(retry_addr),
    .cond_code(cond_code),
    .mem_req(mem_req),
    .mem_we(mem_we),
    .mem_size(mem_size),
    .mem_addr(mem_addr),
    .mem_ack(mem_ack),
    .mem_err(mem_err)
);
`default_nettype wire

// ==== tb/mem_model.sv ====
// Purpose: Memory behind the address translator
// Assumes: Big-endian bytes, 256 locations, address wraps
// Notes: Ack after lag waiting cycles; rdata scrambled outside acks
`timescale 1ns/1ns
`default_nettype none
`include "lsx_consts.svh"
module mem_model
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // Memory link
    input wire logic mem_req,
    input wire logic mem_we,
    input wire logic [1:0] mem_size,
    input wire logic [31:0] mem_addr,
    input wire logic [31:0] mem_wdata,
    output logic mem_ack = 1'h0,
    output logic mem_err = 1'h0,
    output logic [31:0] mem_rdata = 32'h0f0f0f0f,
    // Behaviour set by the bench
    input wire logic [3:0] lag,
    input wire logic [31:0] err_addr
);
    logic [7:0] mem [256];
    logic [3:0] wait_r = 4'h0;
    wire [7:0] a = mem_addr[7:0];
    wire bad = mem_addr == err_addr;
    wire wr = mem_we && !bad;
    always @(posedge ref_clk)
    begin
        if (!rst_n || mem_ack || !mem_req)
        begin
            mem_ack <= 1'h0;
            mem_err <= 1'h0;
            wait_r <= 4'h0;
            mem_rdata <= ~mem_rdata;
        end
        else if (wait_r != lag)
            wait_r <= wait_r + 4'h1;
        else
        begin
            mem_ack <= 1'h1;
            mem_err <= bad;
            mem_rdata <= mem_size == `SIZE_WORD ? {mem[a], mem[a+8'h1], mem[a+8'h2], mem[a+8'h3]} :
                mem_size == `SIZE_HALF ? {16'h0, mem[a], mem[a+8'h1]} : {24'h0, mem[a]};
            if (wr && mem_size == `SIZE_WORD)
                {mem[a], mem[a+8'h1], mem[a+8'h2], mem[a+8'h3]} <= mem_wdata;
            if (wr && mem_size == `SIZE_HALF)
                {mem[a], mem[a+8'h1]} <= mem_wdata[15:0];
            if (wr && mem_size == `SIZE_BYTE)
                mem[a] <= mem_wdata[7:0];
        end
    end
endmodule
`default_nettype wire

// ==== tb/tb_top.sv ====
// Purpose: Self-checking bench for the load/store/exchange unit
// Assumes: clk_en held high; mem_model answers the memory link
// Notes: Reference model keeps registers, flags and memory bytes
`timescale 1ns/1ns
`default_nettype none
`include "lsx_consts.svh"
module tb_top;
    logic ref_clk = '0, rst_n = '0, instr_valid = '0, ext_wr_en = '0;
    logic [7:0] opcode = '0, op;
    logic [3:0] r1_f = '0, r2_f = '0, ext_wr_sel = '0, rd_sel = '0, lag = '0, cond_code, cc = '0;
    logic [31:0] eff_addr = '0, imm_operand = '0, ext_wr_data = '0, err_addr = '1, retry_addr, rd_data;
    logic [31:0] mem_addr, mem_wdata, mem_rdata;
    logic [1:0] mem_size;
    logic instr_ready, done, fault, unknown_op, mem_req, mem_we, mem_ack, mem_err;
    logic [31:0] rf [16];
    logic [7:0] rm [256];
    logic [7:0] ops [14] = '{8'h73, 8'hd1, 8'hd3, 8'h93, 8'h34, 8'h94, 8'h50, 8'h40, 8'hd0, 8'hd2, 8'h92,
        8'h55, 8'h05, 8'hf5};
    int seed = 11, error_cnt = 0, checks = 0, e;
    always #50 ref_clk = ~ref_clk;
    load_store_exchange_exec uut (.ref_clk, .rst_n, .clk_en(1'h1), .instr_valid, .instr_ready, .opcode,
        .first_reg_field(r1_f), .second_reg_field(r2_f), .eff_addr, .imm_operand, .done, .fault, .unknown_op,
        .retry_addr, .cond_code, .ext_wr_en, .ext_wr_sel, .ext_wr_data, .rd_sel, .rd_data, .mem_req, .mem_we,
        .mem_size, .mem_addr, .mem_wdata, .mem_ack, .mem_err, .mem_rdata);
    mem_model mm (.ref_clk, .rst_n, .mem_req, .mem_we, .mem_size, .mem_addr, .mem_wdata, .mem_ack, .mem_err,
        .mem_rdata, .lag, .err_addr);
    function automatic logic [31:0] rdw(int x);
        return {rm[x], rm[x+1], rm[x+2], rm[x+3]};
    endfunction
    task automatic chk(logic [31:0] seen, logic [31:0] want);
        checks++;
        if (seen !== want)
        begin
            error_cnt++;
            $display("BAD %0t seen %h want %h", $time, seen, want);
        end
    endtask
    task automatic give_verdict;
        $display("checks %0d error_cnt %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    // One instruction: drive, wait for done, step the model, compare flags, retry address and registers
    task automatic run(logic [7:0] o, logic [3:0] a, logic [3:0] b, int x);
        int n;
        logic [31:0] v;
        logic hit;
        n = 0;
        hit = 1'h0;
        @(posedge ref_clk);
        #1;
        opcode = o;
        r1_f = a;
        r2_f = b;
        eff_addr = x;
        imm_operand = $random(seed);
        lag = 4'($random(seed)) & 4'h3;
        instr_valid = 1'h1;
        @(posedge ref_clk);
        #1;
        instr_valid = 1'h0;
        while (done !== 1'h1 && n < 200)
        begin
            @(posedge ref_clk);
            #1;
            n++;
        end
        if (n == 200)
            chk(1'h0, 1'h1);
        chk(unknown_op, !(o inside {ops}));
        chk(retry_addr, x);
        v = o == 8'h55 ? rdw(x) : o == 8'h05 ? rf[b] : imm_operand;
        case (o)
            8'h73:
            begin
                rf[a] = {16'h0, rm[x], rm[x+1]};
                cc = rf[a] != 0 ? `CC_GREATER : `CC_ZERO;
            end
            8'hd1, 8'hd0:
                for (int i = a; i < 16 && !hit; i++)
                begin
                    n = x + 4 * (i - a);
                    hit = n == err_addr;
                    if (!hit && o[0])
                        rf[i] = rdw(n);
                    else if (!hit)
                        {rm[n], rm[n+1], rm[n+2], rm[n+3]} = rf[i];
                end
            8'hd3: rf[a] = {24'h0, rm[x]};
            8'h93: rf[a] = {24'h0, rf[b][7:0]};
            8'h34: rf[a] = {rf[b][15:0], rf[b][31:16]};
            8'h94: rf[a][15:0] = {rf[b][7:0], rf[b][15:8]};
            8'h50: {rm[x], rm[x+1], rm[x+2], rm[x+3]} = rf[a];
            8'h40: {rm[x], rm[x+1]} = rf[a][15:0];
            8'hd2: rm[x] = rf[a][7:0];
            8'h92: rf[b][7:0] = rf[a][7:0];
            8'h55, 8'h05, 8'hf5: cc = rf[a] < v ? `CC_LESS : rf[a] > v ? `CC_GREATER : `CC_EQUAL;
            default: ;
        endcase
        chk(fault, hit);
        chk(cond_code, cc);
        for (n = 0; n < 16; n++)
        begin
            rd_sel = n;
            #1;
            chk(rd_data, rf[n]);
        end
    endtask
    initial
    begin
        for (int i = 0; i < 256; i++)
        begin
            rm[i] = $random(seed);
            mm.mem[i] = rm[i];
        end
        repeat (20) @(posedge ref_clk);
        #1;
        rst_n = 1'h1;
        chk(cond_code, `CC_RESET);
        // Back-to-back writes: enable stays up, select and data move each cycle
        for (int i = 0; i < 16; i++)
        begin
            rd_sel = i;
            #1;
            chk(rd_data, `REG_RESET);
            @(posedge ref_clk);
            #1;
            ext_wr_en = 1'h1;
            ext_wr_sel = i;
            ext_wr_data = $random(seed);
            rf[i] = ext_wr_data;
        end
        @(posedge ref_clk);
        #1;
        ext_wr_en = 1'h0;
        {rm[0], rm[1], mm.mem[0], mm.mem[1]} = 32'h0;
        run(8'h73, 4'h2, 4'h0, 0);
        for (int k = 0; k < 84; k++)
        begin
            op = ops[k % 14];
            e = {$random(seed)} % 128;
            e = e & ~(op inside {8'hd3, 8'hd2} ? 0 : op inside {8'h73, 8'h40} ? 1 : 3);
            run(op, $random(seed), $random(seed), e);
        end
        run(8'h34, 4'h5, 4'h5, 0);
        run(8'h94, 4'h7, 4'h7, 0);
        run(8'h05, 4'h3, 4'h3, 0);
        run(8'hd1, 4'h0, 4'h0, 16);
        run(8'hd0, 4'hf, 4'h0, 160);
        err_addr = 32'h2c;
        run(8'hd1, 4'ha, 4'h0, 32'h24);
        err_addr = '1;
        run(8'hff, 4'h1, 4'h2, 0);
        for (int i = 0; i < 256; i++)
            chk(mm.mem[i], rm[i]);
        give_verdict;
    end
    initial
    begin
        #4000000;
        error_cnt++;
        give_verdict;
    end
endmodule
`default_nettype wire
